// ===== hdl/urisc_core.sv
/*
 * Reset, interrupt prioritisation and sleep control of a single UART.
 * Assumes datapath events arrive synchronous to clk as urisc_ev_s.
 */
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module urisc_core #(
   parameter int PINS = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire urisc_pkg::urisc_ev_s ev,
   input wire logic [3:0] modem_in,
   input wire logic rts_pin,
   input wire logic cts_pin,
   input wire logic [PINS-1:0] gpio_in,
   output logic [PINS-1:0] gpio_out,
   output logic [PINS-1:0] gpio_oe,
   output logic tx_line,
   output logic rts_n,
   output logic irq_out,
   output logic irq_oe,
   output logic uart_clk_en,
   output logic rx_ptr_clr,
   output logic tx_write
);
   // ==================================================
   // State
   logic [7:0] ier_q, ier_d, fcr_q, fcr_d, lcr_q, lcr_d, mcr_q, mcr_d;
   logic [7:0] efr_q, efr_d, tcr_q, tcr_d, tlr_q, tlr_d, spr_q, spr_d;
   logic [15:0] div_q, div_d;
   logic [31:0] chars_q, chars_d;
   logic [PINS-1:0] pine_q, pine_d, dir_q, dir_d, pinlast_q, pinlast_d;
   logic [3:0] mdelta_q, mdelta_d, mlast_q, mlast_d;
   logic pinirq_q, pinirq_d, hs_q, hs_d, rlast_q, rlast_d, clast_q, clast_d;
   logic fo_q, fo_d, sp_q, sp_d, srst_q, srst_d, ack_q, ack_d;
   logic [2:0] tcnt_q, tcnt_d;
   logic [5:0] iid;
   logic [7:0] line_status_reg;
   logic wr, rd, rst_all, any_pend, wake;
   logic tout_hit, quiet, pin_set, hs_set;
   logic [6:0] txlvl_q, txlvl_d;
   urisc_pkg::urisc_sleep_e sl_q, sl_d;

   // One wait cycle: read data is captured at the first edge, a write lands at
   // the edge that sees waitrequest low, so the master's view and ours agree
   assign wr = avs_write && ack_q;
   assign rd = avs_read && !ack_q;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   // Pin reset, power-on and software reset share one path
   assign rst_all = !rst_n || srst_q;

   // ==================================================
   // Priority encoder of the eight sources
   function automatic logic [5:0] pick(input logic [7:0] e, input urisc_pkg::urisc_ev_s v,
         input logic to, input logic md, input logic pi, input logic fl, input logic hs);
      logic [5:0] r;
      r = urisc_pkg::ID_NONE;
      if (e[urisc_pkg::B_HS] && hs) r = urisc_pkg::ID_HS;
      if (e[urisc_pkg::B_FLOW] && fl) r = urisc_pkg::ID_FLOW;
      if (pi) r = urisc_pkg::ID_PIN;
      if (e[3] && md) r = urisc_pkg::ID_MODEM;
      if (e[1] && v.thr_req) r = urisc_pkg::ID_THR;
      if (e[0] && v.rx_ready) r = urisc_pkg::ID_RXD;
      if (e[0] && to) r = urisc_pkg::ID_TOUT;
      if (e[2] && v.rx_err_any) r = urisc_pkg::ID_LINE;
      return r;
   endfunction

   // Pin word: enables low byte, directions third byte, levels top byte
   function automatic logic [31:0] pin_word(input logic [PINS-1:0] en,
         input logic [PINS-1:0] dir, input logic [PINS-1:0] lvl);
      logic [31:0] r;
      r = 32'h0;
      r[PINS-1:0] = en;
      r[PINS+15:16] = dir;
      r[PINS+23:24] = lvl;
      return r;
   endfunction

   assign tout_hit = tcnt_q == 3'(urisc_pkg::TOUT_CHARS);
   assign iid = pick(ier_q, ev, tout_hit, |mdelta_q, pinirq_q, fo_q || sp_q, hs_q);
   // Transmit holding is the one source that may stand when sleep is entered
   assign quiet = pick(ier_q & 8'hfd, ev, tout_hit, |mdelta_q, pinirq_q, fo_q || sp_q, hs_q)
                  == urisc_pkg::ID_NONE;
   // Raw set terms, kept apart so a clear on read cannot swallow them
   assign pin_set = |((gpio_in ^ pinlast_q) & pine_q & ~dir_q);
   assign hs_set = (rts_pin && !rlast_q) || (cts_pin && !clast_q);
   // Enabled pending source pulls the line low; released otherwise
   assign any_pend = iid != urisc_pkg::ID_NONE;
   // Head errors only when fifo holds data
   assign line_status_reg = {ev.rx_err_any, ev.tx_empty, ev.tx_empty && ev.thr_req,
                 ev.rx_empty ? 3'h0 : ev.head_err, 1'b0, !ev.rx_empty};

   // ==================================================
   // Next-state for registers, events and sleep
   always_comb begin
      ier_d = ier_q; fcr_d = fcr_q; lcr_d = lcr_q; mcr_d = mcr_q;
      efr_d = efr_q; tcr_d = tcr_q; tlr_d = tlr_q; spr_d = spr_q;
      div_d = div_q; chars_d = chars_q; pine_d = pine_q; dir_d = dir_q;
      srst_d = 1'b0; // Self-clears once the sequence ran
      ack_d = (avs_read || avs_write) && !ack_q;
      mdelta_d = mdelta_q | (modem_in ^ mlast_q);
      mlast_d = modem_in;
      pinlast_d = gpio_in;
      // Pin-change works in sleep too, it never wakes
      pinirq_d = pinirq_q || pin_set;
      // Inactive-going edge of either handshake pin
      hs_d = hs_q || hs_set;
      rlast_d = rts_pin;
      clast_d = cts_pin;
      fo_d = fo_q;
      sp_d = sp_q || ev.special;
      if (ev.flow_on) fo_d = 1'b0;
      if (ev.flow_off) fo_d = 1'b1;
      tcnt_d = tcnt_q;
      // Restart at stop-bit centre and on line status read
      if (ev.rx_empty || ev.rx_ready || ev.stop_centre) tcnt_d = 3'h0;
      else if (ev.char_tick && tcnt_q != 3'(urisc_pkg::TOUT_CHARS)) tcnt_d = tcnt_q + 3'h1;
      // Free space drops per transmit write, refills once the fifo drains
      txlvl_d = txlvl_q;
      if (tx_write && txlvl_q != 7'h00) txlvl_d = txlvl_q - 7'h01;
      else if (ev.tx_empty) txlvl_d = urisc_pkg::RST_TXLVL;
      // Ident read clears the pin, handshake or special-character flag it reports; a new event still wins
      if (rd && avs_address == urisc_pkg::OFS_IIR) begin
         if (iid == urisc_pkg::ID_FLOW) sp_d = ev.special;
         if (iid == urisc_pkg::ID_HS) hs_d = hs_set;
         if (iid == urisc_pkg::ID_PIN) pinirq_d = pin_set;
      end
      if (rd && avs_address == urisc_pkg::OFS_MSR) mdelta_d = modem_in ^ mlast_q;
      if (rd && avs_address == urisc_pkg::OFS_LSR) tcnt_d = 3'h0;
      if (wr) begin
         case (avs_address)
            urisc_pkg::OFS_IER: ier_d = avs_writedata[7:0];
            urisc_pkg::OFS_FCR: fcr_d = avs_writedata[7:0];
            urisc_pkg::OFS_LCR: lcr_d = avs_writedata[7:0];
            urisc_pkg::OFS_MCR: mcr_d = avs_writedata[7:0];
            urisc_pkg::OFS_SPR: spr_d = avs_writedata[7:0];
            urisc_pkg::OFS_EFR: efr_d = avs_writedata[7:0];
            urisc_pkg::OFS_TCR: tcr_d = avs_writedata[7:0];
            urisc_pkg::OFS_TLR: tlr_d = avs_writedata[7:0];
            urisc_pkg::OFS_DIVL: div_d[7:0] = avs_writedata[7:0];
            urisc_pkg::OFS_DIVH: div_d[15:8] = avs_writedata[7:0];
            urisc_pkg::OFS_CHAR: chars_d = avs_writedata;
            urisc_pkg::OFS_PINE: begin
               pine_d = avs_writedata[PINS-1:0];
               dir_d = avs_writedata[PINS+15:16];
            end
            urisc_pkg::OFS_CTRL: srst_d = avs_writedata[urisc_pkg::B_SRST];
            default: ;
         endcase
      end
      // Wake on rx change, modem change or transmit write
      wake = !ev.rx_idle || (modem_in != mlast_q) || tx_write;
      sl_d = sl_q;
      case (sl_q)
         urisc_pkg::URISC_AWAKE:
            // Enable pair plus idle conditions
            if (efr_q[urisc_pkg::B_ENH] && ier_q[urisc_pkg::B_SLEEP] && ev.rx_idle
                && ev.tx_empty && ev.rx_empty && !wake
                && quiet)
               sl_d = urisc_pkg::URISC_ASLEEP;
         urisc_pkg::URISC_ASLEEP:
            // Losing either enable ends sleep as well
            if (wake || !ier_q[urisc_pkg::B_SLEEP] || !efr_q[urisc_pkg::B_ENH])
               sl_d = urisc_pkg::URISC_AWAKE;
         default: sl_d = urisc_pkg::URISC_AWAKE;
      endcase
   end

   // ==================================================
   // Registering; divisor, scratch and characters never reset
   always_ff @(posedge clk) begin
      spr_q <= spr_d;
      div_q <= div_d;
      chars_q <= chars_d;
      mlast_q <= mlast_d;
      pinlast_q <= pinlast_d;
      rlast_q <= rlast_d;
      clast_q <= clast_d;
      if (rst_all) begin
         // Control registers cleared, line control loaded
         ier_q <= 8'h00; fcr_q <= 8'h00; mcr_q <= 8'h00; efr_q <= 8'h00;
         tcr_q <= 8'h00; tlr_q <= 8'h00; lcr_q <= urisc_pkg::RST_LCR;
         pine_q <= '0; dir_q <= '0;
         mdelta_q <= 4'h0;
         pinirq_q <= 1'b0; hs_q <= 1'b0; fo_q <= 1'b0; sp_q <= 1'b0;
         tcnt_q <= 3'h0; sl_q <= urisc_pkg::URISC_AWAKE;
         txlvl_q <= urisc_pkg::RST_TXLVL;
         srst_q <= 1'b0; ack_q <= 1'b0;
      end else begin
         ier_q <= ier_d; fcr_q <= fcr_d; lcr_q <= lcr_d; mcr_q <= mcr_d;
         efr_q <= efr_d; tcr_q <= tcr_d; tlr_q <= tlr_d;
         pine_q <= pine_d; dir_q <= dir_d; mdelta_q <= mdelta_d;
         pinirq_q <= pinirq_d; hs_q <= hs_d; fo_q <= fo_d; sp_q <= sp_d;
         tcnt_q <= tcnt_d; sl_q <= sl_d; srst_q <= srst_d; ack_q <= ack_d;
         txlvl_q <= txlvl_d;
      end
   end

   // ==================================================
   // Read mux, registered so data stands with waitrequest low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0;
      end else if (rd) begin
         case (avs_address)
            urisc_pkg::OFS_IER: avs_readdata <= {24'h0, ier_q};
            urisc_pkg::OFS_IIR: avs_readdata <= {26'h0, iid};
            urisc_pkg::OFS_FCR: avs_readdata <= {24'h0, fcr_q};
            urisc_pkg::OFS_LCR: avs_readdata <= {24'h0, lcr_q};
            urisc_pkg::OFS_MCR: avs_readdata <= {24'h0, mcr_q};
            urisc_pkg::OFS_LSR: avs_readdata <= {24'h0, line_status_reg};
            urisc_pkg::OFS_MSR: avs_readdata <= {24'h0, modem_in, mdelta_q};
            urisc_pkg::OFS_SPR: avs_readdata <= {24'h0, spr_q};
            urisc_pkg::OFS_EFR: avs_readdata <= {24'h0, efr_q};
            urisc_pkg::OFS_TCR: avs_readdata <= {24'h0, tcr_q};
            urisc_pkg::OFS_TLR: avs_readdata <= {24'h0, tlr_q};
            urisc_pkg::OFS_DIVL: avs_readdata <= {24'h0, div_q[7:0]};
            urisc_pkg::OFS_DIVH: avs_readdata <= {24'h0, div_q[15:8]};
            urisc_pkg::OFS_CHAR: avs_readdata <= chars_q;
            // Pin states stay readable while asleep
            urisc_pkg::OFS_PINE: avs_readdata <= pin_word(pine_q, dir_q, gpio_in);
            // Free space, soft reset bit and sleep flag
            urisc_pkg::OFS_CTRL: avs_readdata <= {17'h0, txlvl_q, 4'h0, srst_q, 2'h0,
                                                  sl_q == urisc_pkg::URISC_ASLEEP};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   // ==================================================
   // Pins: idle-high tx and rts, inputs after reset
   assign tx_line = 1'b1;
   assign rts_n = !mcr_q[1];
   assign gpio_out = '0;
   assign gpio_oe = dir_q;
   // Open drain: drive low only; with IER clear only a pin change pulls the line low
   assign irq_out = 1'b0;
   assign irq_oe = any_pend;
   // Clock gated in sleep
   assign uart_clk_en = sl_q == urisc_pkg::URISC_AWAKE;
   assign rx_ptr_clr = rst_all;
   assign tx_write = wr && avs_address == urisc_pkg::OFS_CHAR;

   // ==================================================
   // Checks
   property p_reset_lcr;
      @(posedge clk) !rst_n |=> lcr_q == urisc_pkg::RST_LCR && ier_q == 8'h00;
   endproperty
   a_reset_lcr: assert property (p_reset_lcr) else $error("lcr reset wrong");
   property p_srst;
      @(posedge clk) disable iff (!rst_n) srst_q |=> !srst_q && efr_q == 8'h00;
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset wrong");
   property p_irq;
      @(posedge clk) disable iff (!rst_n) (iid == urisc_pkg::ID_NONE) == !irq_oe;
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
   property p_sleep_en;
      @(posedge clk) disable iff (!rst_n)
         sl_q == urisc_pkg::URISC_ASLEEP
            |-> $past(efr_q[urisc_pkg::B_ENH]) && $past(ier_q[urisc_pkg::B_SLEEP]);
   endproperty
   a_sleep_en: assert property (p_sleep_en) else $error("sleep not enabled");
   property p_wake;
      @(posedge clk) disable iff (!rst_n) sl_q == urisc_pkg::URISC_ASLEEP && tx_write |=> uart_clk_en;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_head;
      @(posedge clk) disable iff (!rst_n) ev.rx_empty |-> line_status_reg[4:2] == 3'h0;
   endproperty
   a_head: assert property (p_head) else $error("head errors not zero");
   property p_line;
      @(posedge clk) disable iff (!rst_n) ier_q[2] && ev.rx_err_any |-> iid == urisc_pkg::ID_LINE;
   endproperty
   a_line: assert property (p_line) else $error("line status priority");
   property p_hs;
      @(posedge clk) disable iff (!rst_n)
         ($rose(cts_pin) || $rose(rts_pin)) && !srst_q |=> hs_q;
   endproperty
   a_hs: assert property (p_hs) else $error("handshake missed");
   property p_tout;
      @(posedge clk) disable iff (!rst_n)
         ier_q[0] && tout_hit && !ev.rx_err_any |-> iid == urisc_pkg::ID_TOUT;
   endproperty
   a_tout: assert property (p_tout) else $error("time-out not reported");
   // Soft reset write, then the pulse, then the cleared registers
   sequence s_srst_req;
      wr && avs_address == urisc_pkg::OFS_CTRL && avs_writedata[urisc_pkg::B_SRST];
   endsequence
   property p_srst_seq;
      @(posedge clk) disable iff (!rst_n)
         s_srst_req |=> srst_q ##1 (ier_q == 8'h00 && lcr_q == urisc_pkg::RST_LCR);
   endproperty
   a_srst_seq: assert property (p_srst_seq) else $error("soft reset sequence wrong");
endmodule

// ===== hdl/urisc_pkg.sv
/*
 * Constants and carrier types of the reset, interrupt and sleep control core.
 * Assumes a single 50 MHz clock, synchronous active-low reset, Avalon-MM slave.
 */
package urisc_pkg;
   // ==================================================
   // Register offsets (word index, byte address = 4 * index)
   localparam logic [3:0] OFS_IER = 4'h0;
   localparam logic [3:0] OFS_IIR = 4'h1;
   localparam logic [3:0] OFS_FCR = 4'h2;
   localparam logic [3:0] OFS_LCR = 4'h3;
   localparam logic [3:0] OFS_MCR = 4'h4;
   localparam logic [3:0] OFS_LSR = 4'h5;
   localparam logic [3:0] OFS_MSR = 4'h6;
   localparam logic [3:0] OFS_SPR = 4'h7;
   localparam logic [3:0] OFS_EFR = 4'h8;
   localparam logic [3:0] OFS_TCR = 4'h9;
   localparam logic [3:0] OFS_TLR = 4'ha;
   localparam logic [3:0] OFS_DIVL = 4'hb;
   localparam logic [3:0] OFS_DIVH = 4'hc;
   localparam logic [3:0] OFS_CHAR = 4'hd;
   localparam logic [3:0] OFS_PINE = 4'he;
   localparam logic [3:0] OFS_CTRL = 4'hf;
   // ==================================================
   // Reset values
   localparam logic [7:0] RST_LCR = 8'h1d;
   localparam logic [6:0] RST_TXLVL = 7'h40;
   localparam logic [7:0] RST_LSR = 8'h60;
   // ==================================================
   // Identification codes
   localparam logic [5:0] ID_NONE = 6'h01;
   localparam logic [5:0] ID_LINE = 6'h06;
   localparam logic [5:0] ID_TOUT = 6'h0c;
   localparam logic [5:0] ID_RXD = 6'h04;
   localparam logic [5:0] ID_THR = 6'h02;
   localparam logic [5:0] ID_MODEM = 6'h00;
   localparam logic [5:0] ID_PIN = 6'h30;
   localparam logic [5:0] ID_FLOW = 6'h10;
   localparam logic [5:0] ID_HS = 6'h20;
   // ==================================================
   // Field positions
   localparam int B_SLEEP = 4;
   localparam int B_FLOW = 5;
   localparam int B_HS = 7;
   localparam int B_ENH = 4;
   localparam int B_SRST = 3;
   localparam int TOUT_CHARS = 4;
   // Sleep state machine
   typedef enum logic [0:0] {URISC_AWAKE, URISC_ASLEEP} urisc_sleep_e;
   // Events from the serial datapath
   typedef struct packed {
      logic rx_ready;     // Receive data above trigger
      logic rx_err_any;   // Some fifo entry has an error
      logic [2:0] head_err; // Break, framing, parity of head
      logic rx_empty;
      logic tx_empty;     // Fifo and shifter empty
      logic thr_req;
      logic stop_centre;  // Pulse at stop-bit centre
      logic char_tick;    // Pulse once per character time
      logic flow_off;
      logic flow_on;
      logic special;
      logic rx_idle;
   } urisc_ev_s;
endpackage

// ===== verif/tb_top.sv
/*
 * Self-checking bench of the reset, interrupt and sleep core.
 * Assumes the host model drives the register bus and the bench drives events.
 */
`timescale 1ns/10ps
module tb_top;
   // ==================================================
   // Signals
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   urisc_pkg::urisc_ev_s ev = '{rx_empty: 1'b1, tx_empty: 1'b1, thr_req: 1'b1,
      rx_idle: 1'b1, default: '0};
   logic [3:0] modem_in = 4'ha;
   logic rts_pin = 1'b0;
   logic cts_pin = 1'b0;
   logic [7:0] gpio_in = 8'h00;
   logic [3:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata, rdv;
   logic [7:0] gpio_out, gpio_oe;
   logic tx_line, rts_n, irq_out, irq_oe, uart_clk_en, rx_ptr_clr, tx_write;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   urisc_core i_urisc_core (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ev(ev),
      .modem_in(modem_in), .rts_pin(rts_pin), .cts_pin(cts_pin), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .tx_line(tx_line), .rts_n(rts_n),
      .irq_out(irq_out), .irq_oe(irq_oe), .uart_clk_en(uart_clk_en),
      .rx_ptr_clr(rx_ptr_clr), .tx_write(tx_write));
   urisc_host_model i_urisc_host_model (.clk(clk), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata));
   // ==================================================
   // Helpers
   task automatic report_and_stop;
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      i_urisc_host_model.wr(a, d);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
      i_urisc_host_model.rd(a, rdv);
      chk($sformatf("reg %h", a), rdv & m, exp);
   endtask
   task automatic ctick(input int n);
      repeat (n) begin
         ev.char_tick <= 1'b1;
         tick(1);
         ev.char_tick <= 1'b0;
         tick(1);
      end
   endtask
   // Bounded wait for the UART clock gate to reach a level
   task automatic wait_clk(input logic lvl);
      int n = 0;
      while (uart_clk_en !== lvl && n < 100) begin
         tick(1);
         n++;
      end
      chk("uart_clk_en", {31'h0, uart_clk_en}, {31'h0, lvl});
   endtask
   task automatic reset_vals;
      logic [3:0] zr [6] = '{urisc_pkg::OFS_IER, urisc_pkg::OFS_FCR, urisc_pkg::OFS_MCR,
         urisc_pkg::OFS_EFR, urisc_pkg::OFS_TCR, urisc_pkg::OFS_TLR};
      foreach (zr[i]) rchk(zr[i], 32'hff, 32'h0);
      rchk(urisc_pkg::OFS_IIR, 32'h3f, 32'h01);
      rchk(urisc_pkg::OFS_LCR, 32'hff, 32'h1d);
      rchk(urisc_pkg::OFS_LSR, 32'hff, 32'h60);
      rchk(urisc_pkg::OFS_MSR, 32'hff, {24'h0, modem_in, 4'h0});
      rchk(urisc_pkg::OFS_PINE, 32'h00ff00ff, 32'h0);
      rchk(urisc_pkg::OFS_CTRL, 32'h7f08, 32'h4000);
      chk("pins", {gpio_out, gpio_oe, 2'h0, irq_out, irq_oe, tx_line, rts_n}, 32'h3);
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // ==================================================
   // Main sequence
   initial begin
      tick(2);
      rst_n <= 1'b1;
      i_urisc_host_model.por_wait();
      reset_vals();
      // Divisor only written while awake
      wr(urisc_pkg::OFS_SPR, 32'h5a);
      wr(urisc_pkg::OFS_DIVL, 32'h34);
      wr(urisc_pkg::OFS_DIVH, 32'h12);
      wr(urisc_pkg::OFS_CHAR, 32'h44332211);
      // Software reset first, then the pin; both must give the same state
      for (int k = 0; k < 2; k++) begin
         wr(urisc_pkg::OFS_LCR, 32'h03);
         wr(urisc_pkg::OFS_IER, 32'h0f);
         modem_in <= modem_in ^ 4'hf;
         tick(3);
         if (k == 0) begin
            wr(urisc_pkg::OFS_CTRL, 32'h08);
            tick(2);
            rchk(urisc_pkg::OFS_CTRL, 32'h08, 32'h0);
         end else begin
            rst_n <= 1'b0;
            tick(2);
            chk("rx_ptr_clr", {31'h0, rx_ptr_clr}, 32'h1);
            rst_n <= 1'b1;
            tick(1);
         end
         reset_vals();
         rchk(urisc_pkg::OFS_SPR, 32'hff, 32'h5a);
         rchk(urisc_pkg::OFS_DIVL, 32'hff, 32'h34);
         rchk(urisc_pkg::OFS_DIVH, 32'hff, 32'h12);
         rchk(urisc_pkg::OFS_CHAR, 32'hffffffff, 32'h44332211);
      end
      // Polled versus interrupt mode
      ev.thr_req <= 1'b0;
      ev.rx_ready <= 1'b1;
      tick(3);
      chk("irq_oe polled", {31'h0, irq_oe}, 32'h0);
      wr(urisc_pkg::OFS_IER, 32'h01);
      tick(2);
      chk("irq_oe armed", {31'h0, irq_oe}, 32'h1);
      // Line, data, THR, modem, pin and flow at once, then peel off from the top priority down
      wr(urisc_pkg::OFS_IER, 32'hef);
      wr(urisc_pkg::OFS_PINE, 32'h000000ff);
      ev.rx_err_any <= 1'b1;
      ev.thr_req <= 1'b1;
      modem_in <= modem_in ^ 4'h1;
      gpio_in <= 8'h01;
      ev.flow_off <= 1'b1;
      tick(1);
      ev.flow_off <= 1'b0;
      tick(2);
      rchk(urisc_pkg::OFS_LSR, 32'h80, 32'h80);
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_LINE});
      ev.rx_err_any <= 1'b0;
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_RXD});
      ev.rx_ready <= 1'b0;
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_THR});
      ev.thr_req <= 1'b0;
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_MODEM});
      i_urisc_host_model.rd(urisc_pkg::OFS_MSR, rdv);
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_PIN});
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_FLOW});
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_FLOW});
      ev.flow_on <= 1'b1;
      tick(1);
      ev.flow_on <= 1'b0;
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_NONE});
      chk("irq_oe idle", {31'h0, irq_oe}, 32'h0);
      cts_pin <= 1'b1;
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_HS});
      rts_pin <= 1'b1;
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_HS});
      ev.special <= 1'b1;
      tick(1);
      ev.special <= 1'b0;
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_FLOW});
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_NONE});
      // Stale data: the stop-bit centre restarts the count
      ev.rx_empty <= 1'b0;
      ctick(3);
      ev.stop_centre <= 1'b1;
      tick(1);
      ev.stop_centre <= 1'b0;
      ctick(3);
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_NONE});
      ctick(1);
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_TOUT});
      ev.head_err <= 3'b101;
      rchk(urisc_pkg::OFS_LSR, 32'h1c, 32'h14);
      ev.rx_empty <= 1'b1;
      rchk(urisc_pkg::OFS_LSR, 32'h1c, 32'h00);
      // Sleep needs both enables and an idle, empty, quiet UART
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      wr(urisc_pkg::OFS_IER, 32'h10);
      tick(20);
      chk("awake no feature", {31'h0, uart_clk_en}, 32'h1);
      ev.rx_empty <= 1'b0;
      wr(urisc_pkg::OFS_EFR, 32'h10);
      tick(20);
      chk("awake rx data", {31'h0, uart_clk_en}, 32'h1);
      ev.rx_empty <= 1'b1;
      wait_clk(1'b0);
      rchk(urisc_pkg::OFS_CTRL, 32'h01, 32'h01);
      wr(urisc_pkg::OFS_PINE, 32'h00000080);
      gpio_in <= 8'h80;
      tick(10);
      chk("gpio no wake", {31'h0, uart_clk_en}, 32'h0);
      rchk(urisc_pkg::OFS_PINE, 32'hff000000, 32'h80000000);
      rchk(urisc_pkg::OFS_IIR, 32'h3f, {26'h0, urisc_pkg::ID_PIN});
      modem_in <= modem_in ^ 4'h2;
      wait_clk(1'b1);
      i_urisc_host_model.rd(urisc_pkg::OFS_MSR, rdv);
      wait_clk(1'b0);
      wr(urisc_pkg::OFS_CHAR, 32'h44332211);
      wait_clk(1'b1);
      report_and_stop();
   end
endmodule

// ===== verif/urisc_host_model.sv
/*
 * Host processor model: an Avalon-MM master that reaches the core registers.
 * Assumes one clock shared with the core and the one-wait-state slave answer.
 */
`timescale 1ns/10ps
module urisc_host_model (
   input wire logic clk,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   output logic [3:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata
);
   // ==================================================
   // Idle bus at time zero
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   // One transfer; request held until an edge that sees waitrequest low
   task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      // Sampled at the rising edge, before that edge's own updates land
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata; // Stands at the same edge that sees waitrequest low
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      xfer(a, 1'b0, 32'h0, q);
   endtask
   // Quiet time after power-on, 3 us at 50 MHz; clock taken as stable after it
   task automatic por_wait;
      repeat (150) @(posedge clk);
   endtask
endmodule
